//--- core/isr_params.svh
// Constants of the status-reporting block: bit positions, masks, reset values, a depth.
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
`define ISR_QD_VOLT        0
`define ISR_QD_CURR        1
`define ISR_QD_RES         9
`define ISR_QD_TEMP        10
`define ISR_QD_TOTAL       11
`define ISR_QD_MEMFULL     12
`define ISR_QD_USED_MASK   16'h1E03
`define ISR_SE_OPC         0
`define ISR_SE_QUERY       2
`define ISR_SE_DEVICE      3
`define ISR_SE_EXEC        4
`define ISR_SE_CMD         5
`define ISR_SE_PON         7
`define ISR_SE_USED_MASK   8'hBD
`define ISR_SE_ERR_MASK    8'h3C
`define ISR_SB_QUES        3
`define ISR_SB_MAV         4
`define ISR_SB_ESB         5
`define ISR_SB_RQS         6
`define ISR_SB_ENA_MASK    8'hBF
`define ISR_QD_RESET       16'h0000
`define ISR_SE_RESET       8'h80
`define ISR_SB_RESET       8'h00
`define ISR_OPC_DEPTH      4
`endif

//--- core/isr_pkg.sv
// Types of the status-reporting block.
package isr_pkg;
	typedef enum logic [3:0] {
		ISR_CMD_NONE = 4'h0,
		ISR_CMD_CLS  = 4'h1,
		ISR_CMD_PRESET = 4'h2,
		ISR_CMD_QD_EVQ = 4'h3,
		ISR_CMD_QD_ENA = 4'h4,
		ISR_CMD_SE_EVQ = 4'h5,
		ISR_CMD_SE_ENA = 4'h6,
		ISR_CMD_SB_ENA = 4'h7,
		ISR_CMD_STBQ = 4'h8,
		ISR_CMD_OPC  = 4'h9,
		ISR_CMD_PSC  = 4'hA,
		ISR_CMD_QD_ENQ = 4'hB,
		ISR_CMD_SE_ENQ = 4'hC,
		ISR_CMD_SB_ENQ = 4'hD
	} isr_cmd_t;
	typedef struct packed {
		isr_cmd_t    op;
		logic [15:0] arg;
	} isr_req_t;
	typedef struct packed {
		logic [4:0] overload;
		logic       total_ovf;
		logic       mem_full;
		logic       query_err;
		logic       device_err;
		logic       exec_err;
		logic       cmd_err;
	} isr_evt_t;
	typedef enum logic [2:0] {
		ISR_OPC_IDLE = 3'b001,
		ISR_OPC_WAIT = 3'b010,
		ISR_OPC_SET  = 3'b100
	} isr_opc_t;
endpackage

//--- core/isr_keep.sv
// Power-cycle retained store for the event enable mask and clear-at-power-on flag.
`timescale 1ns/1ps
`default_nettype none
module isr_keep (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	input  wire logic       psc_we,
	input  wire logic       psc_wdata,
	output var  logic [7:0] rdata,
	output var  logic       psc
);
	// Non-volatile by intent: no reset, so the values survive power-on.
	logic [7:0] mem_q;
	logic       psc_q;
	always_ff @(posedge clk) begin
		if (we) begin
			mem_q <= wdata;
		end
		if (psc_we) begin
			psc_q <= psc_wdata;
		end
		rdata <= we ? wdata : mem_q;
		psc   <= psc_we ? psc_wdata : psc_q;
	end
endmodule
`default_nettype wire

//--- core/isr_status.sv
// Status register groups, status byte and service request logic.
`timescale 1ns/1ps
`default_nettype none
`include "isr_params.svh"
module isr_status (
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic            power_on,
	input  wire logic            req_valid,
	input  wire isr_pkg::isr_req_t req,
	input  wire logic            prior_busy,
	input  wire logic            scan_busy,
	input  wire isr_pkg::isr_evt_t evt,
	input  wire logic            out_pending,
	input  wire logic            serial_poll,
	output logic                 req_ready,
	output logic                 rsp_valid,
	output logic [15:0]          rsp_data,
	output logic [7:0]           poll_byte,
	output logic                 srq_o,
	output logic                 err_push,
	output logic [7:0]           status_byte
);
	logic [15:0] ques_ev_q;
	logic [15:0] ques_en_q;
	logic [7:0]  se_ev_q;
	logic [7:0]  sb_en_q;
	logic        rqs_q;
	logic        mav_q;
	logic        pon_pend_q;
	logic [15:0] ques_set;
	logic [7:0]  se_set;
	logic [7:0]  se_en;
	logic        psc;
	logic        ques_sum;
	logic        se_sum;
	logic [7:0]  sb_cond;
	logic        mss;
	logic        mss_q;
	logic        go;
	logic        ready_d;
	logic        opc_to_wait;
	isr_pkg::isr_opc_t opc_q;

	function automatic logic grp_sum(input logic [15:0] ev, input logic [15:0] en);
		grp_sum = |(ev & en);
	endfunction

	// Commands wait for earlier work; the poll path below bypasses this queue.
	// Ready is registered and a command is taken only where the host sees it high.
	// A late ready therefore never takes one command twice; the cost is one cycle of lag.
	assign opc_to_wait = (opc_q == isr_pkg::ISR_OPC_IDLE && go
		&& req.op == isr_pkg::ISR_CMD_OPC)
		|| (opc_q == isr_pkg::ISR_OPC_WAIT && (prior_busy || scan_busy));
	assign ready_d = !prior_busy && !opc_to_wait;
	assign go = req_valid && req_ready;

	always_comb begin
		ques_set = 16'h0000;
		ques_set[`ISR_QD_VOLT] = evt.overload[0];
		ques_set[`ISR_QD_CURR] = evt.overload[1];
		ques_set[`ISR_QD_RES]  = evt.overload[2] | evt.overload[3];
		ques_set[`ISR_QD_TEMP] = evt.overload[4];
		ques_set[`ISR_QD_TOTAL]   = evt.total_ovf;
		ques_set[`ISR_QD_MEMFULL] = evt.mem_full;
		ques_set = ques_set & `ISR_QD_USED_MASK;
	end

	always_comb begin
		se_set = 8'h00;
		se_set[`ISR_SE_OPC]    = opc_q == isr_pkg::ISR_OPC_SET;
		se_set[`ISR_SE_QUERY]  = evt.query_err;
		se_set[`ISR_SE_DEVICE] = evt.device_err | (|evt.overload);
		se_set[`ISR_SE_EXEC]   = evt.exec_err;
		se_set[`ISR_SE_CMD]    = evt.cmd_err;
		se_set[`ISR_SE_PON]    = pon_pend_q;
		se_set = se_set & `ISR_SE_USED_MASK;
	end

	// Combinational summaries; the registered status byte follows the event registers one cycle later.
	assign ques_sum = grp_sum(ques_ev_q, ques_en_q);
	assign se_sum   = grp_sum({8'h00, se_ev_q}, {8'h00, se_en});

	always_comb begin
		sb_cond = 8'h00;
		sb_cond[`ISR_SB_QUES] = ques_sum;
		sb_cond[`ISR_SB_MAV]  = mav_q;
		sb_cond[`ISR_SB_ESB]  = se_sum;
	end
	assign mss = |(sb_cond & sb_en_q & `ISR_SB_ENA_MASK);

	// Event latching: set wins over clear; a set bit just stays set.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ques_ev_q <= `ISR_QD_RESET;
		end else if (go && (req.op == isr_pkg::ISR_CMD_CLS || req.op == isr_pkg::ISR_CMD_QD_EVQ)) begin
			ques_ev_q <= ques_set;
		end else begin
			ques_ev_q <= ques_ev_q | ques_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			se_ev_q <= 8'h00;
		end else if (go && (req.op == isr_pkg::ISR_CMD_CLS || req.op == isr_pkg::ISR_CMD_SE_EVQ)) begin
			se_ev_q <= se_set;
		end else begin
			se_ev_q <= se_ev_q | se_set;
		end
	end

	// Power-on flag is raised by the power pulse and handed into the event bit once.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pon_pend_q <= 1'b0;
		end else begin
			pon_pend_q <= power_on;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || power_on) begin
			ques_en_q <= `ISR_QD_RESET;
		end else if (go && req.op == isr_pkg::ISR_CMD_PRESET) begin
			ques_en_q <= `ISR_QD_RESET;
		end else if (go && req.op == isr_pkg::ISR_CMD_QD_ENA) begin
			ques_en_q <= req.arg;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sb_en_q <= `ISR_SB_RESET;
		end else if (power_on && psc) begin
			sb_en_q <= `ISR_SB_RESET;
		end else if (go && req.op == isr_pkg::ISR_CMD_SB_ENA) begin
			sb_en_q <= req.arg[7:0] & `ISR_SB_ENA_MASK;
		end
	end

	// The enable mask lives in the retained store, which the power-on pulse clears only while psc is set.
	// A chip reset loads known values, so the summaries never start out unknown.
	isr_keep u_keep (
		.clk       (clk),
		.we        (!resetn || (go && req.op == isr_pkg::ISR_CMD_SE_ENA) || (power_on && psc)),
		.wdata     ((!resetn || (power_on && psc)) ? 8'h00 : req.arg[7:0]),
		.psc_we    (!resetn || (go && req.op == isr_pkg::ISR_CMD_PSC)),
		.psc_wdata (resetn && req.arg[0]),
		.rdata     (se_en),
		.psc       (psc)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			opc_q <= isr_pkg::ISR_OPC_IDLE;
		end else begin
			case (opc_q)
				isr_pkg::ISR_OPC_IDLE: begin
					if (go && req.op == isr_pkg::ISR_CMD_OPC) begin
						opc_q <= isr_pkg::ISR_OPC_WAIT;
					end
				end
				isr_pkg::ISR_OPC_WAIT: begin
					if (!prior_busy && !scan_busy) begin
						opc_q <= isr_pkg::ISR_OPC_SET;
					end
				end
				isr_pkg::ISR_OPC_SET: begin
					opc_q <= isr_pkg::ISR_OPC_IDLE;
				end
				default: begin
					opc_q <= isr_pkg::ISR_OPC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mav_q <= 1'b0;
		end else begin
			mav_q <= out_pending;
		end
	end

	// Request bit: set on rising summary, cleared only by a poll or loss of cause.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mss_q <= 1'b0;
			rqs_q <= 1'b0;
		end else begin
			mss_q <= mss;
			if (mss && !mss_q) begin
				rqs_q <= 1'b1;
			end else if (serial_poll || !mss) begin
				rqs_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			srq_o <= 1'b0;
			poll_byte <= 8'h00;
			status_byte <= 8'h00;
		end else begin
			srq_o <= (mss && !mss_q) || (rqs_q && !serial_poll && mss);
			poll_byte <= sb_cond | {1'b0, rqs_q, 6'h00};
			status_byte <= sb_cond | {1'b0, mss, 6'h00};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			err_push <= 1'b0;
		end else begin
			req_ready <= ready_d;
			// Overload alone sets the device bit but never queues an error.
			err_push <= evt.query_err || evt.device_err
				|| evt.exec_err || evt.cmd_err;
			rsp_valid <= go && (req.op == isr_pkg::ISR_CMD_STBQ
				|| req.op == isr_pkg::ISR_CMD_QD_EVQ || req.op == isr_pkg::ISR_CMD_SE_EVQ
				|| req.op == isr_pkg::ISR_CMD_QD_ENQ || req.op == isr_pkg::ISR_CMD_SE_ENQ
				|| req.op == isr_pkg::ISR_CMD_SB_ENQ);
			case (req.op)
				isr_pkg::ISR_CMD_STBQ:   rsp_data <= {8'h00, sb_cond | {1'b0, mss, 6'h00}};
				isr_pkg::ISR_CMD_QD_EVQ: rsp_data <= ques_ev_q;
				isr_pkg::ISR_CMD_SE_EVQ: rsp_data <= {8'h00, se_ev_q};
				isr_pkg::ISR_CMD_QD_ENQ: rsp_data <= ques_en_q;
				isr_pkg::ISR_CMD_SE_ENQ: rsp_data <= {8'h00, se_en};
				isr_pkg::ISR_CMD_SB_ENQ: rsp_data <= {8'h00, sb_en_q};
				default:                 rsp_data <= 16'h0000;
			endcase
		end
	end

	AST_QUES_SUM: assert property (@(posedge clk) disable iff (!resetn)
		(|(ques_ev_q & ques_en_q)) |=> status_byte[`ISR_SB_QUES] || !resetn)
		else $error("questionable summary missing");
	AST_SE_SUM: assert property (@(posedge clk) disable iff (!resetn)
		(|(se_ev_q & se_en)) |=> status_byte[`ISR_SB_ESB])
		else $error("standard summary missing");
	AST_UNUSED_QD: assert property (@(posedge clk) disable iff (!resetn)
		(ques_ev_q & ~`ISR_QD_USED_MASK) == 16'h0000)
		else $error("unused questionable bit set");
	AST_UNUSED_SE: assert property (@(posedge clk) disable iff (!resetn)
		se_ev_q[1] == 1'b0 && se_ev_q[6] == 1'b0)
		else $error("unused standard bit set");
	AST_OVL_BOTH: assert property (@(posedge clk) disable iff (!resetn)
		|evt.overload |=> se_ev_q[`ISR_SE_DEVICE] && |ques_ev_q)
		else $error("overload not in both groups");
	AST_MAV: assert property (@(posedge clk) disable iff (!resetn)
		out_pending |=> ##1 status_byte[`ISR_SB_MAV])
		else $error("output pending flag missing");
	AST_POLL_CLR: assert property (@(posedge clk) disable iff (!resetn)
		serial_poll && !(mss && !mss_q) |=> !rqs_q)
		else $error("poll did not clear request bit");
	AST_OPC_WAIT: assert property (@(posedge clk) disable iff (!resetn)
		opc_q == isr_pkg::ISR_OPC_WAIT && scan_busy |=> opc_q != isr_pkg::ISR_OPC_SET)
		else $error("completion during scan");
	AST_STBQ_ORDER: assert property (@(posedge clk) disable iff (!resetn)
		req_valid && req.op == isr_pkg::ISR_CMD_STBQ && prior_busy |=> ##1 !rsp_valid)
		else $error("status query ran early");
	AST_BUSY_READY: assert property (@(posedge clk) disable iff (!resetn)
		prior_busy |=> !req_ready)
		else $error("ready while earlier work runs");
	AST_OPC_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
		opc_q == isr_pkg::ISR_OPC_WAIT |-> !req_ready)
		else $error("command taken while completion waits");
	AST_RQS_RISE: assert property (@(posedge clk) disable iff (!resetn)
		mss && !mss_q |=> rqs_q && srq_o)
		else $error("rising summary gave no request");
	AST_ERR_PUSH: assert property (@(posedge clk) disable iff (!resetn)
		evt.query_err || evt.device_err || evt.exec_err || evt.cmd_err |=> err_push)
		else $error("error not queued");
	AST_OVL_NO_PUSH: assert property (@(posedge clk) disable iff (!resetn)
		(|evt.overload) && !(evt.query_err || evt.device_err || evt.exec_err || evt.cmd_err)
		|=> !err_push)
		else $error("overload queued an error");
endmodule
`default_nettype wire

//--- test/isr_host.sv
// Host controller model that sends commands, polls and arms service requests.
`timescale 1ns/1ps
`default_nettype none
module isr_host (
	input  wire logic              clk,
	input  wire logic              req_ready,
	input  wire logic              rsp_valid,
	input  wire logic [15:0]       rsp_data,
	output var  logic              req_valid,
	output var  isr_pkg::isr_req_t req,
	output var  logic              serial_poll
);
	logic [15:0] last_rsp;
	logic        srq_armed;
	initial begin
		req_valid = 1'b0;
		req = '0;
		serial_poll = 1'b0;
		srq_armed = 1'b0;
		last_rsp = 16'h0000;
	end
	// The command is held until an edge samples ready or 200 edges pass, so a ready within that limit never loses it.
	task automatic send(input isr_pkg::isr_cmd_t op, input logic [15:0] arg);
		int n;
		n = 0;
		last_rsp = 16'hFFFF;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= {op, arg};
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 200);
		req_valid <= 1'b0;
		repeat (3) begin
			@(posedge clk);
			if (rsp_valid === 1'b1) last_rsp = rsp_data;
		end
	endtask
	task automatic poll;
		@(posedge clk);
		serial_poll <= 1'b1;
		@(posedge clk);
		serial_poll <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Masks are set and synchronised before the interrupt is armed.
	task automatic setup(input logic [15:0] se, input logic [15:0] sb);
		send(isr_pkg::ISR_CMD_CLS, 16'h0000);
		send(isr_pkg::ISR_CMD_SE_ENA, se);
		send(isr_pkg::ISR_CMD_SB_ENA, sb);
		send(isr_pkg::ISR_CMD_OPC, 16'h0000);
		srq_armed = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- test/instrument_status_reporting_tb.sv
// Self-checking bench for the status-reporting block.
`timescale 1ns/1ps
`default_nettype none
module instrument_status_reporting_tb;
	logic              clk, resetn, power_on, prior_busy, scan_busy, out_pending;
	logic              req_valid, serial_poll, req_ready, rsp_valid, srq_o, err_push;
	isr_pkg::isr_req_t req;
	isr_pkg::isr_evt_t evt;
	logic [15:0]       rsp_data;
	logic [7:0]        poll_byte, status_byte;
	logic              poll_q = 1'b0;
	logic [7:0]        poll_seen = 8'h00;
	int                mismatches = 0, cmp_count = 0, pushes = 0, rsps = 0;
	int                seed = 32'hC3C1FF7F;
	isr_status isr_status_inst (.clk(clk), .resetn(resetn), .power_on(power_on),
		.req_valid(req_valid), .req(req), .prior_busy(prior_busy), .scan_busy(scan_busy),
		.evt(evt), .out_pending(out_pending), .serial_poll(serial_poll),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.poll_byte(poll_byte), .srq_o(srq_o), .err_push(err_push), .status_byte(status_byte));
	isr_host isr_host_inst (.clk(clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .req_valid(req_valid), .req(req), .serial_poll(serial_poll));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		pushes <= pushes + int'(err_push === 1'b1);
		rsps <= rsps + int'(rsp_valid === 1'b1);
		poll_q <= serial_poll;
		if (poll_q === 1'b1) poll_seen <= poll_byte;
	end
	function automatic logic [15:0] qd_of(isr_pkg::isr_evt_t e);
		return {3'h0, e.mem_full, e.total_ovf, e.overload[4], |e.overload[3:2], 7'h00,
			e.overload[1:0]};
	endfunction
	function automatic logic [15:0] se_of(isr_pkg::isr_evt_t e);
		return {10'h000, e.cmd_err, e.exec_err, e.device_err | (|e.overload), e.query_err, 2'h0};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic sb(input int i, input logic v, input string n);
		chk(n, {15'h0000, v}, {15'h0000, status_byte[i]});
	endtask
	task automatic s(input isr_pkg::isr_cmd_t op, input logic [15:0] a);
		isr_host_inst.send(op, a);
	endtask
	task automatic rd(input isr_pkg::isr_cmd_t op, input logic [15:0] exp, input string n);
		isr_host_inst.send(op, 16'h0000);
		chk(n, exp, isr_host_inst.last_rsp);
	endtask
	task automatic ev(input isr_pkg::isr_evt_t e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		cyc(3);
	endtask
	task automatic pwr;
		@(posedge clk);
		power_on <= 1'b1;
		@(posedge clk);
		power_on <= 1'b0;
		cyc(3);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		cyc(5000);
		mismatches++;
		give_verdict;
	end
	initial begin
		isr_pkg::isr_evt_t e;
		logic [15:0]       r;
		int                p;
		resetn = 1'b0;
		power_on = 1'b0;
		prior_busy = 1'b0;
		scan_busy = 1'b0;
		out_pending = 1'b0;
		evt = '0;
		cyc(6);
		resetn <= 1'b1;
		cyc(2);
		chk("status after reset", 16'h0000, {8'h00, status_byte});
		pwr;
		rd(isr_pkg::ISR_CMD_SE_EVQ, 16'h0080, "power event");
		rd(isr_pkg::ISR_CMD_SE_EVQ, 16'h0000, "event cleared");
		$display("test power done");
		// The first pass is overload alone, which must not reach the error queue.
		for (int i = 0; i < 8; i++) begin
			e = isr_pkg::isr_evt_t'(11'($random(seed)));
			if (i == 0) e = '{overload: 5'h1F, default: 1'b0};
			p = pushes;
			ev(e);
			rd(isr_pkg::ISR_CMD_QD_EVQ, qd_of(e), "questionable");
			rd(isr_pkg::ISR_CMD_SE_EVQ, se_of(e), "standard");
			chk("error push", {15'h0000, |e[3:0]}, {15'h0000, pushes != p});
		end
		$display("test events done");
		r = (16'($random(seed)) & 16'h1E03) | 16'h0001;
		s(isr_pkg::ISR_CMD_QD_ENA, r);
		rd(isr_pkg::ISR_CMD_QD_ENQ, r, "ques enable");
		ev('{overload: 5'h01, default: 1'b0});
		sb(3, 1'b1, "ques summary");
		s(isr_pkg::ISR_CMD_QD_EVQ, 16'h0000);
		sb(3, 1'b0, "ques summary cleared");
		s(isr_pkg::ISR_CMD_PRESET, 16'h0000);
		rd(isr_pkg::ISR_CMD_QD_ENQ, 16'h0000, "preset enable");
		s(isr_pkg::ISR_CMD_CLS, 16'h0000);
		$display("test summary done");
		isr_host_inst.setup(16'h0020, 16'h0020);
		ev('{cmd_err: 1'b1, default: 1'b0});
		sb(5, 1'b1, "event summary");
		chk("service line", 16'h0001, {15'h0000, srq_o});
		rd(isr_pkg::ISR_CMD_STBQ, 16'h0060, "status query");
		chk("line kept", 16'h0001, {15'h0000, srq_o});
		isr_host_inst.poll;
		chk("poll byte", 16'h0060, {8'h00, poll_seen});
		chk("poll byte after", 16'h0020, {8'h00, poll_byte});
		chk("line released", 16'h0000, {15'h0000, srq_o});
		s(isr_pkg::ISR_CMD_CLS, 16'h0000);
		sb(5, 1'b0, "summary after clear");
		@(posedge clk) out_pending <= 1'b1;
		cyc(3);
		sb(4, 1'b1, "message pending");
		@(posedge clk) out_pending <= 1'b0;
		cyc(3);
		sb(4, 1'b0, "message drained");
		$display("test request done");
		s(isr_pkg::ISR_CMD_SE_ENA, 16'h0001);
		@(posedge clk) scan_busy <= 1'b1;
		s(isr_pkg::ISR_CMD_OPC, 16'h0000);
		cyc(10);
		sb(5, 1'b0, "complete during scan");
		@(posedge clk) scan_busy <= 1'b0;
		cyc(5);
		sb(5, 1'b1, "complete after scan");
		s(isr_pkg::ISR_CMD_CLS, 16'h0000);
		p = rsps;
		@(posedge clk) prior_busy <= 1'b1;
		fork
			s(isr_pkg::ISR_CMD_STBQ, 16'h0000);
		join_none
		cyc(8);
		chk("early answer", 16'(p), 16'(rsps));
		prior_busy <= 1'b0;
		wait fork;
		chk("late answer", 16'h0001, {15'h0000, rsps > p});
		$display("test ordering done");
		s(isr_pkg::ISR_CMD_SE_ENA, 16'h0024);
		s(isr_pkg::ISR_CMD_QD_ENA, 16'h0003);
		s(isr_pkg::ISR_CMD_PSC, 16'h0000);
		pwr;
		rd(isr_pkg::ISR_CMD_SE_ENQ, 16'h0024, "kept enable");
		rd(isr_pkg::ISR_CMD_QD_ENQ, 16'h0000, "ques power");
		rd(isr_pkg::ISR_CMD_SB_ENQ, 16'h0020, "kept service enable");
		s(isr_pkg::ISR_CMD_PSC, 16'h0001);
		pwr;
		rd(isr_pkg::ISR_CMD_SE_ENQ, 16'h0000, "cleared enable");
		rd(isr_pkg::ISR_CMD_SB_ENQ, 16'h0000, "cleared service enable");
		$display("test power clear done");
		give_verdict;
	end
endmodule
`default_nettype wire
